/* File: shared/dpo_map.svh */
// register offsets, field positions, reset values and timing counts of the output stage
`ifndef DPO_MAP_SVH
`define DPO_MAP_SVH

`define DPO_WORD_W 24
`define DPO_GROUP_W 8
`define DPO_ADDR_W 5

`define DPO_REG_STATUS 5'h00
`define DPO_REG_MASK 5'h04
`define DPO_REG_CTRL 5'h08
`define DPO_REG_STATE 5'h0C

`define DPO_EVT_W 3
`define DPO_EVT_LOCK_UP 0
`define DPO_EVT_LOCK_DOWN 1
`define DPO_EVT_DRIVE_ON 2

`define DPO_CTRL_STEP_LSB 0
`define DPO_CTRL_STEP_W 2
`define DPO_CTRL_STEP_RST 2'h1

`define DPO_ST_LOCK 0
`define DPO_ST_OUT_EN 1
`define DPO_ST_STAGGER 2
`define DPO_ST_RAND_DIS 3
`define DPO_ST_EDGE_SEL 4
`define DPO_ST_DRIVING 5
`define DPO_ST_PHASE 6

`define DPO_HIST_W 16
`define DPO_CNT_MAX 4'hF

`define DPO_LFSR_W 7
`define DPO_LFSR_TAP_A 6
`define DPO_LFSR_TAP_B 5

// step taps, in units of the programmed step; rclk sits at tap 2 when staggered and at tap 1 or 3 when spread
`define DPO_TAP_STG_G0 3'h0
`define DPO_TAP_STG_G1 3'h1
`define DPO_TAP_STG_G2 3'h3
`define DPO_TAP_STG_CK 3'h2
`define DPO_TAP_SPR_CK0 3'h1
`define DPO_TAP_SPR_CK1 3'h3

`endif

/* File: shared/dpo_pkg.sv */
// types shared by the parallel output stage
`default_nettype none
package dpo_pkg;
   `include "dpo_map.svh"

   typedef struct packed {
      logic lock;
      logic out_en;
      logic stagger_sel;
      logic rand_dis;
      logic edge_sel;
   } dpo_pins_t;

   typedef struct packed {
      logic [`DPO_WORD_W-1:0] word;
      logic valid;
   } dpo_word_t;

   typedef enum logic [0:0] {
      DPO_TRI,
      DPO_DRIVE
   } dpo_drive_t;
endpackage : dpo_pkg
`default_nettype wire

/* File: hdl/dpo_derand.sv */
// word de-randomizer: self-synchronising 2e7 descrambler with bypass
`timescale 1ns/1ps
`default_nettype none
module dpo_derand import dpo_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_strobe,
   input wire logic i_bypass,
   input wire logic [`DPO_WORD_W-1:0] i_word,
   output dpo_word_t o_out
);
   logic [`DPO_LFSR_W-1:0] lfsr;
   logic [`DPO_LFSR_W-1:0] next_lfsr;
   dpo_word_t next_out;

   // bit 0 first; each received bit shifts into the history
   function automatic logic [`DPO_LFSR_W+`DPO_WORD_W-1:0] descramble(
      input logic [`DPO_WORD_W-1:0] w,
      input logic [`DPO_LFSR_W-1:0] st);
      logic [`DPO_LFSR_W-1:0] s;
      logic [`DPO_WORD_W-1:0] o;
      s = st;
      o = '0;
      for (int i = 0; i < `DPO_WORD_W; i++) begin
         o[i] = w[i] ^ s[`DPO_LFSR_TAP_A] ^ s[`DPO_LFSR_TAP_B];
         s = {s[`DPO_LFSR_W-2:0], w[i]};
      end
      return {s, o};
   endfunction : descramble

   always_comb begin
      next_lfsr = lfsr;
      next_out = '{word: o_out.word, valid: 1'b0};
      if (i_strobe) begin
         next_out.valid = 1'b1;
         if (i_bypass) begin
            next_out.word = i_word; // see RULE7
         end else begin
            {next_lfsr, next_out.word} = descramble(i_word, lfsr); // see RULE8
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lfsr <= '0;
         o_out <= '0;
      end else begin
         lfsr <= next_lfsr;
         o_out <= next_out;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_bypass_plain;
      i_strobe && i_bypass |=> o_out.valid && (o_out.word == $past(i_word));
   endproperty
   a_bypass_plain: assert property (p_bypass_plain) // see RULE7
      else $error("bypass word altered");

   property p_derand_bit0;
      i_strobe && !i_bypass |=> o_out.word[0] ==
         ($past(i_word[0]) ^ $past(lfsr[`DPO_LFSR_TAP_A]) ^ $past(lfsr[`DPO_LFSR_TAP_B]));
   endproperty
   a_derand_bit0: assert property (p_derand_bit0) // see RULE8
      else $error("descrambled bit 0 wrong");
endmodule : dpo_derand
`default_nettype wire

/* File: hdl/dpo_top.sv */
// parallel output stage of the link receiver: word launch, group timing, tri-state, registers
//
// Functional notes
// RULE1: the recovered clock is driven out and its strobe edge follows the edge-select input.
// RULE2: the word leaves on 24 outputs in three bytes, bits 7-0, 15-8 and 23-16.
// RULE3: the lock output is high while the receiver PLL is locked and low otherwise.
// RULE4: while lock is low all data outputs and the clock output are high impedance.
// RULE5: staggered select high switches the three byte groups at offsets one to two steps apart.
// RULE6: staggered select low spreads the groups over one to two steps and the clock by one step (here groups at 0, 3, 4 or 0, 1, 4 steps, clock at 1 or 3).
// RULE7: randomizer-disable high selects the legacy mode where words pass undescrambled.
// RULE8: randomizer-disable low, the default, descrambles with the 2e7 shift register.
// RULE9: output enable high lets the data and clock outputs be driven.
// RULE10: output enable low tri-states data and clock while lock keeps tracking the PLL.
// RULE11: data launch on the rising clock edge when edge-select is high, else on the falling.
// RULE12: outputs drive only when lock and output enable are both high.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dpo_top import dpo_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_link_clk,
   input wire logic i_pll_lock,
   input wire logic [`DPO_WORD_W-1:0] i_rx_word,
   input wire logic i_output_enable,
   input wire logic i_staggered_turn_on_select,
   input wire logic i_randomizer_disable,
   input wire logic i_output_edge_select,
   input wire logic [`DPO_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   output logic [`DPO_WORD_W-1:0] o_parallel_data_out,
   output logic o_parallel_data_oe,
   output logic o_rclk,
   output logic o_rclk_oe,
   output logic o_lock
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers
   logic rst_meta;
   logic rst_n;
   dpo_pins_t pin_meta;
   dpo_pins_t pin_s;
   logic lclk_meta;
   logic lclk_s;
   logic [`DPO_WORD_W-1:0] word_meta;
   logic [`DPO_WORD_W-1:0] word_s;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_s <= '0;
         lclk_meta <= 1'b0;
         lclk_s <= 1'b0;
         word_meta <= '0;
         word_s <= '0;
      end else begin
         pin_meta <= '{lock: i_pll_lock, out_en: i_output_enable,
                       stagger_sel: i_staggered_turn_on_select,
                       rand_dis: i_randomizer_disable, edge_sel: i_output_edge_select};
         pin_s <= pin_meta;
         lclk_meta <= i_link_clk;
         lclk_s <= lclk_meta;
         word_meta <= i_rx_word;
         word_s <= word_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link clock edges, history and launch strobe
   logic [`DPO_HIST_W-1:0] hist;
   logic [`DPO_HIST_W-1:0] next_hist;
   logic rise;
   logic fall;
   logic strobe;
   dpo_word_t dword;

   always_comb begin
      next_hist = {hist[`DPO_HIST_W-2:0], lclk_s};
      rise = lclk_s & ~hist[0];
      fall = ~lclk_s & hist[0];
      strobe = pin_s.edge_sel ? rise : fall; // see RULE11
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= '0;
      end else begin
         hist <= next_hist;
      end
   end

   dpo_derand u_derand (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_strobe(strobe),
      .i_bypass(pin_s.rand_dis), // see RULE7
      .i_word(word_s),
      .o_out(dword)
   );

   ////////////////////////////////////////////////////////////////////////////
   // group timing: each byte and the clock pick a tap times the step
   logic [`DPO_CTRL_STEP_W-1:0] ctrl_step;
   logic [`DPO_CTRL_STEP_W-1:0] step;
   logic phase;
   logic next_phase;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [2:0] pend;
   logic [2:0] next_pend;
   logic [`DPO_WORD_W-1:0] pend_word;
   logic [`DPO_WORD_W-1:0] next_pend_word;
   logic [`DPO_WORD_W-1:0] next_data;
   logic [3:0] ck_dly;

   // idx 0..2 byte groups, 3 the clock
   function automatic logic [2:0] tap_of(input logic [1:0] idx, input logic stg,
                                         input logic ph);
      logic [2:0] t;
      t = `DPO_TAP_STG_CK;
      if (stg) begin
         case (idx)
            2'h0: t = `DPO_TAP_STG_G0;
            2'h1: t = `DPO_TAP_STG_G1;
            2'h2: t = `DPO_TAP_STG_G2;
            default: t = `DPO_TAP_STG_CK;
         endcase
      end else begin
         case (idx)
            2'h0: t = ph ? 3'h4 : 3'h0;
            2'h1: t = ph ? 3'h0 : 3'h4;
            2'h2: t = ph ? 3'h1 : 3'h3;
            default: t = ph ? `DPO_TAP_SPR_CK1 : `DPO_TAP_SPR_CK0;
         endcase
      end
      return t;
   endfunction : tap_of

   function automatic logic [3:0] dly_of(input logic [2:0] t,
                                         input logic [`DPO_CTRL_STEP_W-1:0] s);
      return 4'(t) * 4'(s);
   endfunction : dly_of

   always_comb begin
      step = (ctrl_step == '0) ? `DPO_CTRL_STEP_RST : ctrl_step;
      next_phase = phase;
      next_cnt = (cnt == `DPO_CNT_MAX) ? cnt : 4'(cnt + 4'h1);
      next_pend = pend;
      next_pend_word = pend_word;
      next_data = o_parallel_data_out;
      for (int g = 0; g < 3; g++) begin
         if (pend[g] && cnt == dly_of(tap_of(2'(g), pin_s.stagger_sel, phase), step)) begin
            next_data[g*`DPO_GROUP_W +: `DPO_GROUP_W] =
               pend_word[g*`DPO_GROUP_W +: `DPO_GROUP_W]; // see RULE2 RULE5 RULE6
            next_pend[g] = 1'b0;
         end
      end
      if (dword.valid) begin
         next_pend_word = dword.word;
         next_pend = 3'h7;
         next_cnt = 4'h0;
         next_phase = pin_s.stagger_sel ? 1'b0 : ~phase; // see RULE6
      end
      ck_dly = dly_of(tap_of(2'h3, pin_s.stagger_sel, phase), step);
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 1'b0;
         cnt <= `DPO_CNT_MAX;
         pend <= '0;
         pend_word <= '0;
         o_parallel_data_out <= '0;
         o_rclk <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         pend <= next_pend;
         pend_word <= next_pend_word;
         o_parallel_data_out <= next_data;
         o_rclk <= hist[ck_dly]; // see RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // drive control, lock and events
   dpo_drive_t drv;
   dpo_drive_t next_drv;
   logic enable;
   logic [`DPO_EVT_W-1:0] evt;

   always_comb begin
      enable = pin_s.lock & pin_s.out_en; // see RULE12
      next_drv = drv;
      case (drv)
         DPO_TRI: if (enable && dword.valid) next_drv = DPO_DRIVE; // see RULE9
         DPO_DRIVE: if (!enable) next_drv = DPO_TRI; // see RULE4 RULE10
         default: next_drv = DPO_TRI;
      endcase
      evt = '0;
      evt[`DPO_EVT_LOCK_UP] = pin_s.lock & ~o_lock;
      evt[`DPO_EVT_LOCK_DOWN] = ~pin_s.lock & o_lock;
      evt[`DPO_EVT_DRIVE_ON] = (next_drv == DPO_DRIVE) && (drv == DPO_TRI);
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         drv <= DPO_TRI;
         o_parallel_data_oe <= 1'b0;
         o_rclk_oe <= 1'b0;
         o_lock <= 1'b0;
      end else begin
         drv <= next_drv;
         o_parallel_data_oe <= (next_drv == DPO_DRIVE);
         o_rclk_oe <= (next_drv == DPO_DRIVE);
         o_lock <= pin_s.lock; // see RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon-mm slave, status, mask, control and interrupt
   logic [`DPO_EVT_W-1:0] status;
   logic [`DPO_EVT_W-1:0] next_status;
   logic [`DPO_EVT_W-1:0] mask;
   logic [`DPO_EVT_W-1:0] next_mask;
   logic [`DPO_CTRL_STEP_W-1:0] next_ctrl_step;
   logic next_wait;
   logic [31:0] next_rdata;
   logic do_wr;
   logic [`DPO_EVT_W-1:0] clr;

   always_comb begin
      next_wait = ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
      do_wr = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
      clr = '0;
      next_mask = mask;
      next_ctrl_step = ctrl_step;
      if (do_wr) begin
         case (i_avs_address)
            `DPO_REG_STATUS: clr = i_avs_writedata[`DPO_EVT_W-1:0];
            `DPO_REG_MASK: next_mask = i_avs_writedata[`DPO_EVT_W-1:0];
            `DPO_REG_CTRL: next_ctrl_step =
               i_avs_writedata[`DPO_CTRL_STEP_LSB +: `DPO_CTRL_STEP_W];
            default: clr = '0;
         endcase
      end
      // a new event wins over a simultaneous clear
      next_status = (status & ~clr) | evt;
      next_rdata = o_avs_readdata;
      if (i_avs_read && o_avs_waitrequest) begin
         next_rdata = '0;
         case (i_avs_address)
            `DPO_REG_STATUS: next_rdata[`DPO_EVT_W-1:0] = status;
            `DPO_REG_MASK: next_rdata[`DPO_EVT_W-1:0] = mask;
            `DPO_REG_CTRL: next_rdata[`DPO_CTRL_STEP_LSB +: `DPO_CTRL_STEP_W] = ctrl_step;
            `DPO_REG_STATE: begin
               next_rdata[`DPO_ST_LOCK] = pin_s.lock;
               next_rdata[`DPO_ST_OUT_EN] = pin_s.out_en;
               next_rdata[`DPO_ST_STAGGER] = pin_s.stagger_sel;
               next_rdata[`DPO_ST_RAND_DIS] = pin_s.rand_dis;
               next_rdata[`DPO_ST_EDGE_SEL] = pin_s.edge_sel;
               next_rdata[`DPO_ST_DRIVING] = (drv == DPO_DRIVE);
               next_rdata[`DPO_ST_PHASE] = phase;
            end
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
         mask <= '0;
         ctrl_step <= `DPO_CTRL_STEP_RST;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= '0;
         o_irq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         ctrl_step <= next_ctrl_step;
         o_avs_waitrequest <= next_wait;
         o_avs_readdata <= next_rdata;
         o_irq <= |(next_status & next_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_launch_stg;
      dword.valid && pin_s.stagger_sel && step == 2'h1;
   endsequence
   sequence s_groups_stg;
      ##2 (o_parallel_data_out[7:0] == $past(dword.word[7:0], 2))
      ##1 (o_parallel_data_out[15:8] == $past(dword.word[15:8], 3))
      ##2 (o_parallel_data_out[23:16] == $past(dword.word[23:16], 5));
   endsequence

   property p_lock_follow;
      pin_s.lock != o_lock |=> o_lock == $past(pin_s.lock);
   endproperty
   a_lock_follow: assert property (p_lock_follow) // see RULE3
      else $error("lock output not tracking pll");

   property p_tri_unlocked;
      !o_lock |-> !o_parallel_data_oe && !o_rclk_oe;
   endproperty
   a_tri_unlocked: assert property (p_tri_unlocked) // see RULE4
      else $error("outputs driven while unlocked");

   property p_drive_on;
      enable && dword.valid |=> o_parallel_data_oe && o_rclk_oe;
   endproperty
   a_drive_on: assert property (p_drive_on) // see RULE9
      else $error("outputs not driven after launch");

   property p_oe_off_keeps_lock;
      $fell(pin_s.out_en) && pin_s.lock |=> !o_parallel_data_oe && !o_rclk_oe && o_lock;
   endproperty
   a_oe_off_keeps_lock: assert property (p_oe_off_keeps_lock) // see RULE10
      else $error("disable did not tri-state or dropped lock");

   property p_launch_edge;
      dword.valid |-> $past(pin_s.edge_sel ? rise : fall);
   endproperty
   a_launch_edge: assert property (p_launch_edge) // see RULE11
      else $error("word launched on wrong clock edge");

   property p_both_needed;
      o_parallel_data_oe |-> $past(pin_s.lock) && $past(pin_s.out_en);
   endproperty
   a_both_needed: assert property (p_both_needed) // see RULE12
      else $error("driven without lock and enable");

   property p_stagger_groups;
      s_launch_stg |-> s_groups_stg;
   endproperty
   a_stagger_groups: assert property (p_stagger_groups) // see RULE2 RULE5
      else $error("staggered group timing wrong");

   property p_spread_group;
      dword.valid && !pin_s.stagger_sel && phase && step == 2'h1
         |-> ##5 (o_parallel_data_out[15:8] == $past(o_parallel_data_out[15:8], 4))
         ##1 (o_parallel_data_out[15:8] == $past(dword.word[15:8], 6));
   endproperty
   a_spread_group: assert property (p_spread_group) // see RULE6
      else $error("spread group timing wrong");

   property p_rclk_follows;
      $rose(lclk_s) |-> ##[1:14] $rose(o_rclk);
   endproperty
   a_rclk_follows: assert property (p_rclk_follows) // see RULE1
      else $error("recovered clock not driven out");
endmodule : dpo_top
`default_nettype wire

/* File: bench/dpo_sink_model.sv */
// downstream pixel sink model: resolves the tri-state pins and counts strobe edges
`timescale 1ns/1ps
`default_nettype none
module dpo_sink_model (
   input wire logic i_clk,
   input wire logic [23:0] i_data,
   input wire logic i_data_oe,
   input wire logic i_rclk,
   input wire logic i_rclk_oe,
   input wire logic i_edge_sel,
   output logic [23:0] o_pins,
   output logic [15:0] o_strobes
);
   logic [23:0] last = 24'h00_0000;
   logic rclk_q = 1'h0;
   logic [15:0] cnt = 16'h0000;
   // released pins float: show the inverse of the last level
   assign o_pins = i_data_oe ? i_data : ~last;
   assign o_strobes = cnt;
   always @(posedge i_clk) begin
      last <= o_pins;
      rclk_q <= i_rclk;
      if (i_rclk_oe && rclk_q != i_rclk && i_rclk == i_edge_sel) begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule : dpo_sink_model
`default_nettype wire

/* File: bench/tb_deserializer_parallel_output_control.sv */
// self-checking bench of the parallel output stage
`timescale 1ns/1ps
`default_nettype none
`include "dpo_map.svh"
module tb_deserializer_parallel_output_control;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic lclk = 1'h0;
   logic lock = 1'h0;
   logic oe = 1'h0;
   logic stg = 1'h0;
   logic rdis = 1'h1;
   logic esel = 1'h1;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [3:0] be = 4'hF;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [23:0] word = 24'h00_0000;
   logic [23:0] prev = 24'h00_0000;
   logic [31:0] rdata;
   logic waitreq, irq, doe, rclk, rclk_oe, lk, ph;
   logic [23:0] dout, pins;
   logic [15:0] strobes;
   int failures = 0;
   int compares = 0;
   int seed = 82;

   always #2.5 clk = ~clk;

   dpo_top dpo_top_inst (
      .i_core_clk(clk), .i_resetn(rst_n), .i_link_clk(lclk), .i_pll_lock(lock),
      .i_rx_word(word), .i_output_enable(oe), .i_staggered_turn_on_select(stg),
      .i_randomizer_disable(rdis), .i_output_edge_select(esel), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
      .o_parallel_data_out(dout), .o_parallel_data_oe(doe), .o_rclk(rclk),
      .o_rclk_oe(rclk_oe), .o_lock(lk));

   dpo_sink_model dpo_sink_model_inst (
      .i_clk(clk), .i_data(dout), .i_data_oe(doe), .i_rclk(rclk), .i_rclk_oe(rclk_oe),
      .i_edge_sel(esel), .o_pins(pins), .o_strobes(strobes));

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
         input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'h0 && n < 50);
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
      if (n >= 50) begin
         failures++;
         stop_test();
      end
   endtask : bus

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, 4'hF, q);
   endtask : wreg

   task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
         input string nm);
      logic [31:0] q;
      bus(1'h0, a, 32'h0000_0000, 4'hF, q);
      chk(nm, e, q & m);
   endtask : rchk

   function automatic logic [23:0] rnd24();
      rnd24 = 24'($random(seed));
   endfunction : rnd24

   // reference descrambler, x^7+x^6+1, bit 0 first
   function automatic logic [23:0] derand(input logic [23:0] p, input logic [23:0] c);
      logic [30:0] x;
      x = {c, p[23:17]};
      for (int i = 0; i < 24; i++) begin
         derand[i] = x[i + 7] ^ x[i] ^ x[i + 1];
      end
   endfunction : derand

   function automatic logic [23:0] offs(input int a, input int b, input int c, input int s);
      offs = {8'(a * s), 8'(b * s), 8'(c * s)};
   endfunction : offs

   // one link period; the word stands only around the chosen edge, junk around the other
   task automatic send_word(input logic [23:0] w);
      @(posedge clk);
      #1 word = w;
      #15 lclk = esel;
      #16 word = ~w;
      #16 lclk = !esel;
      #16;
   endtask : send_word

   task automatic watch(output int t[3]);
      logic [23:0] p;
      p = dout;
      t = '{-1, -1, -1};
      for (int c = 0; c < 40; c++) begin
         @(posedge clk);
         #1;
         for (int g = 0; g < 3; g++) begin
            if (t[g] < 0 && dout[g * 8 +: 8] !== p[g * 8 +: 8]) begin
               t[g] = c;
            end
         end
      end
   endtask : watch

   task automatic timed(input int s);
      int t[3];
      int m;
      logic [23:0] w, got, e0, e1;
      logic [15:0] n0;
      w = prev ^ (rnd24() | 24'h01_0101);
      n0 = strobes;
      fork
         send_word(w);
         watch(t);
      join
      prev = w;
      m = (t[0] < t[1]) ? t[0] : t[1];
      m = (t[2] < m) ? t[2] : m;
      got = {8'(t[0] - m), 8'(t[1] - m), 8'(t[2] - m)};
      e0 = stg ? offs(0, 1, 3, s) : offs(0, 4, 3, s);
      e1 = offs(4, 0, 1, s);
      ph = stg ? 1'h0 : !ph; // phase flips at every spread launch
      chk("group offsets", (stg || !ph) ? e0 : e1, got);
      chk("pins", w, pins);
      chk("rclk strobes", 1, 32'(strobes - n0));
   endtask : timed

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      #400_000;
      failures++;
      stop_test();
   end

   initial begin
      logic [31:0] q;
      logic [23:0] w;
      cyc(16);
      chk("reset flags", 32'h0000_0001, {doe, rclk_oe, irq, lk, waitreq});
      chk("reset data", 32'h0000_0000, dout);
      rst_n <= 1'h1;
      cyc(4);
      rchk(`DPO_REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, "ctrl reset");
      rchk(`DPO_REG_MASK, 32'h0000_0000, 32'hFFFF_FFFF, "mask reset");
      rchk(`DPO_REG_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, "status reset");
      bus(1'h1, `DPO_REG_CTRL, 32'h0000_0003, 4'hE, q);
      rchk(`DPO_REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, "ctrl byte lanes");
      wreg(5'h10, 32'hFFFF_FFFF);
      rchk(5'h10, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
      wreg(`DPO_REG_MASK, 32'h0000_0007);
      lock <= 1'h1;
      cyc(8);
      chk("lock up", 3, {irq, lk});
      rchk(`DPO_REG_STATUS, 32'h0000_0001, 32'hFFFF_FFFF, "lock gained");
      wreg(`DPO_REG_STATUS, 32'h0000_0001);
      cyc(3);
      chk("irq cleared", 0, irq);
      wreg(`DPO_REG_MASK, 32'h0000_0000);
      lock <= 1'h0;
      cyc(8);
      chk("lock down", 0, {irq, lk});
      rchk(`DPO_REG_STATUS, 32'h0000_0002, 32'hFFFF_FFFF, "lock lost");
      wreg(`DPO_REG_STATUS, 32'h0000_0002);
      oe <= 1'h1;
      send_word(rnd24());
      cyc(20);
      chk("drive unlocked", 0, {doe, rclk_oe});
      lock <= 1'h1;
      cyc(8);
      wreg(`DPO_REG_MASK, 32'h0000_0004);
      prev = rnd24();
      send_word(prev);
      cyc(20);
      chk("drive on", 7, {doe, rclk_oe, irq});
      rchk(`DPO_REG_STATE, 32'h0000_003B, 32'h0000_003F, "state");
      wreg(`DPO_REG_STATUS, 32'h0000_0007);
      wreg(`DPO_REG_MASK, 32'h0000_0000);
      oe <= 1'h0;
      cyc(8);
      chk("enable low", 1, {doe, rclk_oe, lk});
      oe <= 1'h1;
      prev = rnd24();
      send_word(prev);
      cyc(20);
      chk("enable high", 3, {doe, rclk_oe});
      lock <= 1'h0;
      cyc(8);
      chk("lock loss", 0, {doe, rclk_oe, lk});
      lock <= 1'h1;
      prev = rnd24();
      send_word(prev);
      cyc(20);
      ph = 1'h0; // four spread launches so far
      for (int e = 0; e < 2; e++) begin
         esel <= e[0];
         cyc(8);
         #1 lclk = !esel;
         for (int sp = 0; sp < 2; sp++) begin
            stg <= sp[0];
            for (int s = 0; s < 4; s++) begin
               wreg(`DPO_REG_CTRL, 32'(s));
               cyc(4);
               repeat (4) timed((s == 0) ? 1 : s);
            end
         end
      end
      rdis <= 1'h0;
      cyc(8);
      for (int i = 0; i < 12; i++) begin
         w = rnd24();
         send_word(w);
         cyc(30);
         if (i > 0) begin
            chk("descrambled", derand(prev, w), pins);
         end
         prev = w;
      end
      stop_test();
   end
endmodule : tb_deserializer_parallel_output_control
`default_nettype wire
